// >>> hw/video_level_proc.sv
// Level adjust, RGB matrix and 4:2:2 downformatter with APB settings.
// Assumes stream inputs come from logic on clk_sys and one sample per valid.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "level_defs.svh"

module video_level_proc (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire level_pkg::apb_req_type apb_i,
  output level_pkg::apb_rsp_type     apb_o,
  input  wire level_pkg::ycc_type    dec_i,
  input  wire level_pkg::raw_type    raw_i,
  input  wire level_pkg::rgb_type    rgb_i,
  output level_pkg::ycc_type         dec_o,
  output level_pkg::raw_type         raw_o,
  output level_pkg::fmt_type         fmt_o
);
  import level_pkg::*;

  typedef struct packed {
    logic [7:0]  con;
    logic [7:0]  bri;
    logic [7:0]  sat;
    logic [7:0]  rgain;
    logic [7:0]  rofs;
    logic        byp;
    logic        filt;
    logic        pready;
    logic        perr;
    logic [31:0] prdata;
    logic        s1_valid;
    logic        s1_byp;
    logic [8:0]  s1_y;
    logic [8:0]  s1_r;
    logic [8:0]  s1_b;
    logic        s2_valid;
    logic [8:0]  s2_y;
    logic [8:0]  s2_cb;
    logic [8:0]  s2_cr;
    logic [8:0]  yh1;
    logic [8:0]  yh2;
    logic [8:0]  cbh1;
    logic [8:0]  cbh2;
    logic [8:0]  crh1;
    logic [8:0]  crh2;
    logic        sa_valid;
    logic        sa_ph;
    logic        ph;
    logic [8:0]  yf;
    logic [8:0]  cbf;
    logic [8:0]  crf;
    logic [8:0]  crd;
    fmt_type     out;
    logic [15:0] cnt;
  } main_state_type;

  main_state_type     st_q;
  main_state_type     st_d;
  logic               setup;
  logic               access;
  sel_type            sel;
  logic [19:0]        ysum;
  logic signed [9:0]  db;
  logic signed [9:0]  dr;
  logic signed [20:0] pcb;
  logic signed [20:0] pcr;
  logic signed [12:0] hp_e;
  logic [10:0]        lp_cb;
  logic [10:0]        lp_cr;

  // Register decode, shared by read and write
  function automatic sel_type reg_sel(input logic [7:0] a);
    unique case (a)
      `DEC_ADDR:  reg_sel = SEL_DEC;
      `RAW_ADDR:  reg_sel = SEL_RAW;
      `MODE_ADDR: reg_sel = SEL_MODE;
      `STAT_ADDR: reg_sel = SEL_STAT;
      `FILT_ADDR: reg_sel = SEL_FILT;
      default:    reg_sel = SEL_NONE;
    endcase
  endfunction

  // Limit to the 9-bit range
  function automatic logic [8:0] clamp9(input logic signed [12:0] v);
    if (v < 13'sh0000) begin
      clamp9 = 9'h000;
    end else if (v > 13'sh01ff) begin
      clamp9 = 9'h1ff;
    end else begin
      clamp9 = v[8:0];
    end
  endfunction

  assign setup  = apb_i.psel && !apb_i.penable;
  assign access = apb_i.psel && apb_i.penable && st_q.pready;
  assign sel    = reg_sel(apb_i.paddr);

  // Next state of bus slave and datapath
  always_comb begin
    st_d = st_q;
    ysum  = 20'(rgb_i.r) * 20'(`K_R) + 20'(rgb_i.g) * 20'(`K_G) + 20'(rgb_i.b) * 20'(`K_B) + `K_RND;
    db    = $signed({1'b0, st_q.s1_b}) - $signed({1'b0, st_q.s1_y});
    dr    = $signed({1'b0, st_q.s1_r}) - $signed({1'b0, st_q.s1_y});
    pcb   = $signed({1'b0, `K_CB}) * db;
    pcr   = $signed({1'b0, `K_CR}) * dr;
    hp_e  = $signed({3'b000, st_q.yh1, 1'b0}) - $signed({4'h0, st_q.s2_y})
            - $signed({4'h0, st_q.yh2});
    lp_cb = 11'(st_q.s2_cb) + 11'({st_q.cbh1, 1'b0}) + 11'(st_q.cbh2);
    lp_cr = 11'(st_q.s2_cr) + 11'({st_q.crh1, 1'b0}) + 11'(st_q.crh2);

    // APB answer, one wait-free access phase
    st_d.pready = setup;
    if (setup) begin
      st_d.perr   = (sel == SEL_NONE);
      st_d.prdata = '0;
      if (!apb_i.pwrite) begin
        unique case (sel)
          SEL_DEC:  st_d.prdata = {8'h00, st_q.sat, st_q.bri, st_q.con};
          SEL_RAW:  st_d.prdata = {16'h0000, st_q.rofs, st_q.rgain};
          SEL_MODE: st_d.prdata = {31'h0, st_q.byp};
          SEL_STAT: st_d.prdata = {st_q.cnt, 15'h0, st_q.out.phase};
          SEL_FILT: st_d.prdata = {31'h0, st_q.filt};
          SEL_NONE: st_d.prdata = '0;
        endcase
      end
    end else if (access) begin
      st_d.perr = 1'b0;
    end
    if (access && apb_i.pwrite) begin
      unique case (sel)
        SEL_DEC: begin
          st_d.con = apb_i.pwdata[`CON_LSB +: 8];
          st_d.bri = apb_i.pwdata[`BRI_LSB +: 8];
          st_d.sat = apb_i.pwdata[`SAT_LSB +: 8];
        end
        SEL_RAW: begin
          st_d.rgain = apb_i.pwdata[`RGAIN_LSB +: 8];
          st_d.rofs  = apb_i.pwdata[`ROFS_LSB +: 8];
        end
        SEL_MODE: st_d.byp  = apb_i.pwdata[0];
        SEL_FILT: st_d.filt = apb_i.pwdata[0];
        SEL_STAT: st_d.cnt  = '0;
        SEL_NONE: st_d.cnt  = st_q.cnt;
      endcase
    end

    // Matrix stage 1: luma sum or bypass copy
    st_d.s1_valid = rgb_i.valid;
    if (rgb_i.valid) begin
      st_d.s1_byp = st_q.byp;
      st_d.s1_r   = rgb_i.r;
      st_d.s1_b   = rgb_i.b;
      st_d.s1_y   = st_q.byp ? rgb_i.g : ysum[`K_FRAC +: 9];
    end

    // Matrix stage 2: colour differences, bypass of equal depth
    st_d.s2_valid = st_q.s1_valid;
    if (st_q.s1_valid) begin
      st_d.s2_y = st_q.s1_y;
      if (st_q.s1_byp) begin
        st_d.s2_cb = st_q.s1_b;
        st_d.s2_cr = st_q.s1_r;
      end else begin
        st_d.s2_cb = clamp9(13'(pcb >>> `K_FRAC) + `MID9);
        st_d.s2_cr = clamp9(13'(pcr >>> `K_FRAC) + `MID9);
      end
    end

    // Filter taps and stage A: chroma low-pass, luma high-pass
    st_d.sa_valid = st_q.s2_valid;
    if (st_q.s2_valid) begin
      st_d.yh1  = st_q.s2_y;
      st_d.yh2  = st_q.yh1;
      st_d.cbh1 = st_q.s2_cb;
      st_d.cbh2 = st_q.cbh1;
      st_d.crh1 = st_q.s2_cr;
      st_d.crh2 = st_q.crh1;
      st_d.cbf  = lp_cb[10:2];
      st_d.crf  = lp_cr[10:2];
      if (st_q.filt) begin
        st_d.yf = clamp9($signed({4'h0, st_q.yh1}) + (hp_e >>> `HP_SHIFT));
      end else begin
        st_d.yf = st_q.yh1;
      end
      st_d.sa_ph = st_q.ph;
      st_d.ph    = !st_q.ph;
    end

    // Multiplexer before the output register
    st_d.out.valid = st_q.sa_valid;
    if (st_q.sa_valid) begin
      st_d.crd       = st_q.crf;
      st_d.out.phase = st_q.sa_ph;
      st_d.out.y     = st_q.yf;
      st_d.out.c     = st_q.sa_ph ? st_q.crd : st_q.cbf;
      st_d.cnt       = st_q.cnt + 16'h0001;
    end
  end

  // State register with reset levels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q       <= '0;
      st_q.con   <= `CON_RST;
      st_q.bri   <= `BRI_RST;
      st_q.sat   <= `SAT_RST;
      st_q.rgain <= `RGAIN_RST;
      st_q.rofs  <= `ROFS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Decoder luma and chroma, raw composite adjust
  level_adjust #(.DIV(`DIV_CON)) u_adj_y (
    .clk_sys (clk_sys),
    .rst     (rst),
    .valid_i (dec_i.valid),
    .x_i     (dec_i.y),
    .gain_i  (st_q.con),
    .ofs_i   (st_q.bri),
    .valid_o (dec_o.valid),
    .res_o   (dec_o.y)
  );

  level_adjust #(.DIV(`DIV_SAT)) u_adj_cb (
    .clk_sys (clk_sys),
    .rst     (rst),
    .valid_i (dec_i.valid),
    .x_i     (dec_i.cb),
    .gain_i  (st_q.sat),
    .ofs_i   (`MID8),
    .valid_o (),
    .res_o   (dec_o.cb)
  );

  level_adjust #(.DIV(`DIV_SAT)) u_adj_cr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .valid_i (dec_i.valid),
    .x_i     (dec_i.cr),
    .gain_i  (st_q.sat),
    .ofs_i   (`MID8),
    .valid_o (),
    .res_o   (dec_o.cr)
  );

  level_adjust #(.DIV(`DIV_SAT)) u_adj_raw (
    .clk_sys (clk_sys),
    .rst     (rst),
    .valid_i (raw_i.valid),
    .x_i     (raw_i.s),
    .gain_i  (st_q.rgain),
    .ofs_i   (st_q.rofs),
    .valid_o (raw_o.valid),
    .res_o   (raw_o.s)
  );

  assign apb_o = '{pready: st_q.pready, pslverr: st_q.perr, prdata: st_q.prdata};
  assign fmt_o = st_q.out;

  // Checks
  sequence cb_slot;
    st_q.sa_valid && !st_q.sa_ph;
  endsequence

  sequence cr_slot;
    st_q.sa_valid && st_q.sa_ph;
  endsequence

  AST_RESET_LEVELS: assert property (@(posedge clk_sys)
    $fell(rst) |-> (st_q.con == `CON_RST && st_q.bri == `BRI_RST && st_q.sat == `SAT_RST))
    else $error("decoder levels not at defaults after reset");

  AST_RAW_RESET: assert property (@(posedge clk_sys)
    $fell(rst) |-> (st_q.rgain == `RGAIN_RST && st_q.rofs == `ROFS_RST))
    else $error("raw levels not at defaults after reset");

  AST_CB_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
    cb_slot |=> (fmt_o.valid && !fmt_o.phase && fmt_o.c == $past(st_q.cbf)))
    else $error("slot start did not carry blue difference");

  AST_CR_ALIGNED: assert property (@(posedge clk_sys) disable iff (rst)
    cb_slot ##1 cr_slot |=> (fmt_o.phase && fmt_o.c == $past(st_q.crf, 2)))
    else $error("red difference not from the slot's first sample");

  AST_BYPASS_DEPTH: assert property (@(posedge clk_sys) disable iff (rst)
    (rgb_i.valid && st_q.byp) |-> ##2 (st_q.s2_valid && st_q.s2_y == $past(rgb_i.g, 2)))
    else $error("bypass latency differs from matrix");

  AST_FILTER_OFF: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.s2_valid && !st_q.filt) |=> st_q.yf == $past(st_q.yh1))
    else $error("luma changed with the high-pass off");

  AST_APB_ANSWER: assert property (@(posedge clk_sys) disable iff (rst)
    setup |=> (apb_o.pready ##1 !apb_o.pready))
    else $error("bus answer not one cycle after setup");

endmodule // video_level_proc
`default_nettype wire

// >>> hw/level_defs.svh
// Constants of the video level, matrix and downformatter datapath.
// Assumes a 250 MHz clk_sys and an APB slave with byte addresses on paddr[7:0].
// Contract
// - Luma out is trunc(contrast/68 times (Y-128)) plus brightness.
// - Chroma out is trunc(saturation/64 times (C-128)) plus 128.
// - Reset levels: contrast 44H, brightness 80H, saturation 40H.
// - Raw out is trunc(raw_gain/64 times (CVBS-128)) plus raw_offset.
// - Reset raw levels: raw_gain 64, raw_offset 128.
// - Every adjusted luma, chroma and raw result is clamped to 1..254.
// - Matrix luma weights are 0.299 red, 0.587 green, 0.114 blue.
// - Blue difference 0.5772 times (B-Y), red difference 0.7296 times (R-Y).
// - Matrix takes and gives 9-bit words with overall unity gain.
// - Component input bypasses the matrix with equal latency.
// - Both colour differences are low-pass filtered before downsampling.
// - Red difference is delayed one sample to match the slot's first luma.
// - Phase is 0 on a slot's first clock, carrying blue difference.
// - Multiplexed chroma is registered after the multiplexer.
// - Luma high-pass from delay registers: unity DC, about 2 dB at Nyquist.
// - Luma high-pass output is limited to 0..511.
// - ypath_filter_enable switches the high-pass; software writes index 29H.
`ifndef LEVEL_DEFS_SVH
`define LEVEL_DEFS_SVH

// Register byte addresses
`define DEC_ADDR   8'h00
`define RAW_ADDR   8'h04
`define MODE_ADDR  8'h08
`define STAT_ADDR  8'h0c
`define FILT_IDX   8'h29
`define FILT_ADDR  (8'(`FILT_IDX * 4))

// Field positions
`define CON_LSB    0
`define BRI_LSB    8
`define SAT_LSB    16
`define RGAIN_LSB  0
`define ROFS_LSB   8
`define CNT_LSB    16

// Reset values
`define CON_RST    8'h44
`define BRI_RST    8'h80
`define SAT_RST    8'h40
`define RGAIN_RST  8'h40
`define ROFS_RST   8'h80

// Level arithmetic
`define MID8       8'h80
`define DIV_CON    18'sh44
`define DIV_SAT    18'sh40
`define LIM_LO     8'h01
`define LIM_HI     8'hfe

// Matrix coefficients, scaled by 2^10
`define K_FRAC     10
`define K_RND      20'h00200
`define K_R        10'h132
`define K_G        10'h259
`define K_B        10'h075
`define K_CB       11'h24f
`define K_CR       11'h2eb
`define MID9       13'sh0100
`define HP_SHIFT   4

`endif

// >>> hw/level_pkg.sv
// Types shared by the level datapath and its adjust stage.
// Assumes level_defs.svh is compiled alongside.
`default_nettype none
package level_pkg;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
  } ycc_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] s;
  } raw_type;

  // In bypass r, g, b carry Cr, Y, Cb
  typedef struct packed {
    logic       valid;
    logic [8:0] r;
    logic [8:0] g;
    logic [8:0] b;
  } rgb_type;

  typedef struct packed {
    logic       valid;
    logic       phase;
    logic [8:0] y;
    logic [8:0] c;
  } fmt_type;

  typedef enum logic [2:0] {
    SEL_DEC  = 3'b000,
    SEL_RAW  = 3'b001,
    SEL_MODE = 3'b010,
    SEL_STAT = 3'b011,
    SEL_FILT = 3'b100,
    SEL_NONE = 3'b111
  } sel_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] res;
  } adj_state_type;

endpackage
`default_nettype wire

// >>> hw/level_adjust.sv
// One level adjust stage: scaled gain around 128, offset, limit.
// Assumes samples and settings come from logic on clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "level_defs.svh"

module level_adjust #(
  parameter logic signed [17:0] DIV = `DIV_SAT
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       valid_i,
  input  wire logic [7:0] x_i,
  input  wire logic [7:0] gain_i,
  input  wire logic [7:0] ofs_i,
  output logic            valid_o,
  output logic [7:0]      res_o
);
  import level_pkg::*;

  adj_state_type      st_q;
  adj_state_type      st_d;
  logic signed [17:0] prod;
  logic signed [17:0] quo;
  logic signed [11:0] sum;

  // Scale, truncate, offset, limit
  always_comb begin
    prod = $signed({1'b0, gain_i}) * ($signed({2'b00, x_i}) - $signed({2'b00, `MID8}));
    quo  = prod / DIV;
    sum  = 12'(quo) + $signed({4'h0, ofs_i});
    st_d = st_q;
    st_d.valid = valid_i;
    if (valid_i) begin
      if (sum < $signed({4'h0, `LIM_LO})) begin
        st_d.res = `LIM_LO;
      end else if (sum > $signed({4'h0, `LIM_HI})) begin
        st_d.res = `LIM_HI;
      end else begin
        st_d.res = sum[7:0];
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign valid_o = st_q.valid;
  assign res_o   = st_q.res;

  AST_LEVEL_LIMIT: assert property (@(posedge clk_sys) disable iff (rst)
    valid_o |-> (res_o >= `LIM_LO && res_o <= `LIM_HI))
    else $error("adjusted level outside 1..254");

  AST_UNITY_SETTING: assert property (@(posedge clk_sys) disable iff (rst)
    (valid_i && gain_i == 8'h40 && ofs_i == 8'h80 && DIV == `DIV_SAT) |=>
      res_o == (($past(x_i) < `LIM_LO) ? `LIM_LO : ($past(x_i) > `LIM_HI) ? `LIM_HI : $past(x_i)))
    else $error("unity gain setting altered the sample");

endmodule // level_adjust
`default_nettype wire

// >>> sim/fmt_sink.sv
// Far-side model: scaler, slicer and output formatter taking every sample.
// Assumes all streams share clk_sys and carry no back-pressure.
`timescale 1ns/1ns
`default_nettype none

module fmt_sink (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire level_pkg::ycc_type dec_i,
  input  wire level_pkg::raw_type raw_i,
  input  wire level_pkg::fmt_type fmt_i,
  output logic [15:0]             taken_q
);
  import level_pkg::*;

  // Counts every sample the three consumers take
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      taken_q <= 16'h0000;
    end else begin
      taken_q <= taken_q + 16'(dec_i.valid) + 16'(raw_i.valid) + 16'(fmt_i.valid);
    end
  end
endmodule // fmt_sink

`default_nettype wire

// >>> sim/video_level_proc_tb.sv
// Self-checking bench for the level, matrix and downformatter datapath.
// Assumes level_defs.svh and level_pkg are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "level_defs.svh"

module video_level_proc_tb;
  import level_pkg::*;
  logic        clk_sys;
  logic        rst;
  apb_req_type apb_i;
  apb_rsp_type apb_o;
  ycc_type     dec_i;
  ycc_type     dec_o;
  raw_type     raw_i;
  raw_type     raw_o;
  rgb_type     rgb_i;
  fmt_type     fmt_o;
  logic [15:0] taken;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          check_count;

  video_level_proc dut (.clk_sys(clk_sys), .rst(rst), .apb_i(apb_i), .apb_o(apb_o), .dec_i(dec_i),
    .raw_i(raw_i), .rgb_i(rgb_i), .dec_o(dec_o), .raw_o(raw_o), .fmt_o(fmt_o));
  fmt_sink sink (.clk_sys(clk_sys), .rst(rst), .dec_i(dec_o), .raw_i(raw_o), .fmt_i(fmt_o), .taken_q(taken));

  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Matrix results allow one code of rounding slack
  task automatic near(input logic [8:0] got, input int exp, input string what);
    check_count++;
    if ($isunknown(got) || int'(got) > exp + 1 || int'(got) < exp - 1) begin
      failures++;
      $display("unexpected at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // Scaled level around 128, truncated toward zero, then limited
  function automatic logic [31:0] lvl(input int x, input int g, input int ofs, input int div);
    int r;
    r = (g * (x - 128)) / div + ofs;
    if (r < 1) r = 1;
    if (r > 254) r = 254;
    return 32'(r);
  endfunction

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    apb_i <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_sys);
    apb_i.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (apb_o.pready === 1'b1) break;
    end
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    if (n == 20) begin
      failures++;
      end_sim;
    end
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  // One decoder and raw sample, judged one cycle later
  task automatic dec_one(input int y, input int c, input int con, input int bri, input int sat,
                         input int rg, input int ro);
    @(posedge clk_sys);
    dec_i <= '{1'b1, 8'(y), 8'(c), 8'(255 - c)};
    raw_i <= '{1'b1, 8'(y)};
    @(posedge clk_sys);
    dec_i.valid <= 1'b0;
    raw_i.valid <= 1'b0;
    @(negedge clk_sys);
    check(dec_o.valid, 1'b1, "decoder valid");
    check(raw_o.valid, 1'b1, "raw valid");
    check(dec_o.y, lvl(y, con, bri, 68), "luma");
    check(dec_o.cb, lvl(c, sat, 128, 64), "blue diff");
    check(dec_o.cr, lvl(255 - c, sat, 128, 64), "red diff");
    check(raw_o.s, lvl(y, rg, ro, 64), "raw");
  endtask

  task automatic reset_values;
    apb(1'b0, `DEC_ADDR, 32'h0);
    check(rd, 32'h00408044, "decoder defaults");
    apb(1'b0, `RAW_ADDR, 32'h0);
    check(rd, 32'h00008040, "raw defaults");
    apb(1'b0, `FILT_ADDR, 32'h0);
    check(rd, 32'h0, "filter default");
    apb(1'b0, 8'h10, 32'h0);
    check(32'(err), 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped read");
  endtask

  task automatic level_stage;
    int t[6] = '{0, 255, 16, 127, 200, 130};
    foreach (t[i]) dec_one(t[i], t[5 - i], 8'h44, 8'h80, 8'h40, 64, 128);
    apb(1'b1, `DEC_ADDR, 32'h00201022);
    apb(1'b1, `RAW_ADDR, 32'h000010ff);
    foreach (t[i]) dec_one(t[i], t[5 - i], 8'h22, 8'h10, 8'h20, 255, 16);
  endtask

  // Streams RGB every cycle; odd samples swap g and b for the second values
  task automatic fmt_run(input int r, input int g0, input int g1, input int b0, input int b1,
                         input int y0, input int y1, input int ecb, input int ecr, input string what);
    int e;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys);
      rgb_i <= '{1'b1, 9'(r), 9'(i % 2 ? g1 : g0), 9'(i % 2 ? b1 : b0)};
      @(negedge clk_sys);
      if (i >= 10) begin
        check(fmt_o.valid, 1'b1, what);
        check(fmt_o.phase, 32'(i % 2), what);
        // Output luma trails the phase count by one sample: phase 0 shows the odd values
        e = (fmt_o.phase === 1'b1) ? y0 : y1;
        near(fmt_o.y, e, what);
        near(fmt_o.c, fmt_o.phase === 1'b1 ? ecr : ecb, what);
      end
    end
    @(posedge clk_sys);
    rgb_i.valid <= 1'b0;
  endtask

  task automatic matrix_and_filter;
    fmt_run(200, 200, 200, 200, 200, 200, 200, 256, 256, "grey");
    fmt_run(400, 0, 0, 0, 0, 120, 120, 187, 460, "red");
    fmt_run(0, 0, 0, 400, 400, 46, 46, 460, 222, "blue");
    apb(1'b1, `MODE_ADDR, 32'h1);
    apb(1'b0, `MODE_ADDR, 32'h0);
    check(rd, 32'h1, "bypass mode");
    fmt_run(400, 100, 300, 0, 400, 100, 300, 200, 400, "bypass");
    apb(1'b1, `FILT_ADDR, 32'h1);
    apb(1'b0, `FILT_ADDR, 32'h0);
    check(rd, 32'h1, "filter enable");
    fmt_run(400, 100, 300, 50, 50, 75, 325, 50, 400, "high-pass");
    fmt_run(400, 0, 511, 50, 50, 0, 511, 50, 400, "limit");
    fmt_run(400, 200, 200, 50, 50, 200, 200, 50, 400, "dc");
    // Let the pipeline drain; seven runs of 24 samples, last phase 1
    repeat (4) @(posedge clk_sys);
    apb(1'b0, `STAT_ADDR, 32'h0);
    check(rd, 32'h00a80001, "sample count");
    apb(1'b1, `STAT_ADDR, 32'h0);
    apb(1'b0, `STAT_ADDR, 32'h0);
    check(rd, 32'h00000001, "count cleared");
  endtask

  // Cuts a hang short
  initial begin
    #100000;
    failures++;
    $display("unexpected at %0t: timeout", $time);
    end_sim;
  end

  initial begin
    failures = 0;
    check_count = 0;
    rst = 1'b1;
    apb_i = '0;
    dec_i = '0;
    raw_i = '0;
    rgb_i = '0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    reset_values();
    level_stage();
    matrix_and_filter();
    check(32'(taken != 16'h0000), 32'h1, "samples taken");
    end_sim;
  end
endmodule // video_level_proc_tb

`default_nettype wire
